// ===== verilog/sfsc_cfg.svh
`ifndef SFSC_CFG_SVH
`define SFSC_CFG_SVH

`define SFSC_ADDR_W          6
`define SFSC_DATA_W          16
`define SFSC_ADDR_CONTROL    6'h03
`define SFSC_ADDR_STATUS     6'h12
`define SFSC_ADDR_CONFIG     6'h3f
`define SFSC_BIT_LATCH_SEL   4
`define SFSC_BIT_UV_FLAG     3
`define SFSC_BIT_OV_FLAG     2
`define SFSC_BIT_THERM_MASK  3
`define SFSC_BIT_ULD_MASK    1
`define SFSC_BIT_PWM_SWAP    0
`define SFSC_ULD_CHANNELS    4
`define SFSC_RESET_WORD      16'h0000

`endif

// ===== verilog/sfsc_pkg.sv
`include "sfsc_cfg.svh"

package sfsc_pkg;

   typedef struct packed {
      logic uv;
      logic ov;
   } sfsc_supply_t;

   typedef struct packed {
      logic therm_mask;
      logic uld_mask;
      logic pwm_swap;
   } sfsc_config_t;

   typedef struct packed {
      logic [`SFSC_ADDR_W-1:0] addr;
      logic                    wr_en;
      logic                    rd_en;
      logic [`SFSC_DATA_W-1:0] wdata;
   } sfsc_req_t;

endpackage

// ===== verilog/sfsc_top.sv
`timescale 1ns/1ps
`include "sfsc_cfg.svh"

module sfsc_top (
   input  wire logic                               clk_sys,
   input  wire logic                               rst_n,
   input  wire sfsc_pkg::sfsc_req_t                reg_req,
   output logic      [`SFSC_DATA_W-1:0]            reg_rdata_q,
   output logic                                    reg_rvalid_q,
   input  wire sfsc_pkg::sfsc_supply_t             supply_fault_det,
   input  wire logic                               thermal_warning_raw,
   input  wire logic [`SFSC_ULD_CHANNELS-1:0]      underload_event,
   input  wire logic                               underload_global_clear,
   input  wire logic                               pwm_input_one,
   input  wire logic                               pwm_input_two,
   output logic                                    output_stage_enable_q,
   output logic                                    thermal_warning_global_q,
   output logic                                    underload_global_q,
   output logic                                    half_bridge_one_pwm_q,
   output logic                                    half_bridge_two_pwm_q
);

   logic                   rst_sync1_q;
   logic                   rst_sync2_q;
   logic                   supply_fault_latch_select_q;
   sfsc_pkg::sfsc_config_t cfg_q;
   sfsc_pkg::sfsc_supply_t flags_q;
   sfsc_pkg::sfsc_supply_t flags_d;
   logic                   status_read;
   logic                   fault_block;
   logic                   latched_hold;

   function automatic logic hit(
      input logic [`SFSC_ADDR_W-1:0] a,
      input logic [`SFSC_ADDR_W-1:0] target
   );
      hit = (a == target);
   endfunction

   // Reset release is synchronised so all flops behind the two-flop synchroniser leave reset on the same edge
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end
      else
      begin
         rst_sync1_q <= 1'b1;
         rst_sync2_q <= rst_sync1_q;
      end
   end

   assign status_read = reg_req.rd_en && hit(reg_req.addr, `SFSC_ADDR_STATUS);

   // Configuration writes
   always_ff @(posedge clk_sys or negedge rst_sync2_q)
   begin
      if (!rst_sync2_q)
      begin
         supply_fault_latch_select_q <= 1'b0;
         cfg_q                       <= '0;
      end
      else if (reg_req.wr_en)
      begin
         // Writes to the status word or unmapped addresses are dropped silently
         if (hit(reg_req.addr, `SFSC_ADDR_CONTROL))
         begin
            supply_fault_latch_select_q <= reg_req.wdata[`SFSC_BIT_LATCH_SEL];
         end
         else if (hit(reg_req.addr, `SFSC_ADDR_CONFIG))
         begin
            cfg_q.therm_mask <= reg_req.wdata[`SFSC_BIT_THERM_MASK];
            cfg_q.uld_mask   <= reg_req.wdata[`SFSC_BIT_ULD_MASK];
            cfg_q.pwm_swap   <= reg_req.wdata[`SFSC_BIT_PWM_SWAP];
         end
      end
   end

   // A present fault re-asserts the flag, so a read never loses an event
   always_comb
   begin
      flags_d = flags_q;
      if (status_read)
      begin
         flags_d = '0;
      end
      if (supply_fault_det.uv)
      begin
         flags_d.uv = 1'b1;
      end
      if (supply_fault_det.ov)
      begin
         flags_d.ov = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync2_q)
   begin
      if (!rst_sync2_q)
      begin
         flags_q <= '0;
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   // Latched mode holds off on the stored flags until a status read clears them
   assign latched_hold = supply_fault_latch_select_q && (flags_q.uv || flags_q.ov);
   // Auto mode blocks only while a condition is live, so outputs return by themselves
   assign fault_block  = supply_fault_det.uv || supply_fault_det.ov || latched_hold;

   always_ff @(posedge clk_sys or negedge rst_sync2_q)
   begin
      if (!rst_sync2_q)
      begin
         output_stage_enable_q <= 1'b0;
      end
      else
      begin
         output_stage_enable_q <= !fault_block;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync2_q)
   begin
      if (!rst_sync2_q)
      begin
         thermal_warning_global_q <= 1'b0;
      end
      else
      begin
         thermal_warning_global_q <= thermal_warning_raw && !cfg_q.therm_mask;
      end
   end

   // Set wins over clear; the mask forces the flag low outright
   always_ff @(posedge clk_sys or negedge rst_sync2_q)
   begin
      if (!rst_sync2_q)
      begin
         underload_global_q <= 1'b0;
      end
      else if (cfg_q.uld_mask)
      begin
         underload_global_q <= 1'b0;
      end
      else if (|underload_event)
      begin
         underload_global_q <= 1'b1;
      end
      else if (underload_global_clear)
      begin
         underload_global_q <= 1'b0;
      end
   end

   // PWM paths are registered, adding one cycle of delay
   always_ff @(posedge clk_sys or negedge rst_sync2_q)
   begin
      if (!rst_sync2_q)
      begin
         half_bridge_one_pwm_q <= 1'b0;
         half_bridge_two_pwm_q <= 1'b0;
      end
      else
      begin
         half_bridge_one_pwm_q <= pwm_input_one;
         half_bridge_two_pwm_q <= cfg_q.pwm_swap ? pwm_input_one : pwm_input_two;
      end
   end

   // Read data shows pre-clear flag values
   always_ff @(posedge clk_sys or negedge rst_sync2_q)
   begin
      if (!rst_sync2_q)
      begin
         reg_rdata_q  <= `SFSC_RESET_WORD;
         reg_rvalid_q <= 1'b0;
      end
      else
      begin
         reg_rvalid_q <= reg_req.rd_en;
         reg_rdata_q  <= `SFSC_RESET_WORD;
         // Unmapped reads still answer, with an all-zero word
         if (reg_req.rd_en)
         begin
            if (hit(reg_req.addr, `SFSC_ADDR_STATUS))
            begin
               reg_rdata_q[`SFSC_BIT_UV_FLAG] <= flags_q.uv;
               reg_rdata_q[`SFSC_BIT_OV_FLAG] <= flags_q.ov;
            end
            else if (hit(reg_req.addr, `SFSC_ADDR_CONFIG))
            begin
               reg_rdata_q[`SFSC_BIT_THERM_MASK] <= cfg_q.therm_mask;
               reg_rdata_q[`SFSC_BIT_ULD_MASK]   <= cfg_q.uld_mask;
               reg_rdata_q[`SFSC_BIT_PWM_SWAP]   <= cfg_q.pwm_swap;
            end
            else if (hit(reg_req.addr, `SFSC_ADDR_CONTROL))
            begin
               reg_rdata_q[`SFSC_BIT_LATCH_SEL] <= supply_fault_latch_select_q;
            end
         end
      end
   end

endmodule

// ===== test/sfsc_chk.sv
`timescale 1ns/1ps
module sfsc_chk (
   input wire logic                   clk_sys,
   input wire logic                   rst_n,
   input wire sfsc_pkg::sfsc_req_t    reg_req,
   input wire logic [15:0]            reg_rdata_q,
   input wire logic                   reg_rvalid_q,
   input wire sfsc_pkg::sfsc_supply_t supply_fault_det,
   input wire logic                   thermal_warning_raw,
   input wire logic [3:0]             underload_event,
   input wire logic                   pwm_input_one,
   input wire logic                   pwm_input_two,
   input wire logic                   output_stage_enable_q,
   input wire logic                   thermal_warning_global_q,
   input wire logic                   underload_global_q,
   input wire logic                   half_bridge_one_pwm_q,
   input wire logic                   half_bridge_two_pwm_q
);
   // Internal reset trails rst_n by two flops, so checks wait a few edges
   logic [2:0] up_q;
   wire        live = up_q[2];
   wire        uld_any = |underload_event;
   logic       therm_mask_q;
   logic       uld_mask_q;
   // Mask copies follow the bus writes, since the checker sees only the pins
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) {therm_mask_q, uld_mask_q} <= 2'h0;
      else if (reg_req.wr_en && reg_req.addr == 6'h3f)
         {therm_mask_q, uld_mask_q} <= {reg_req.wdata[3], reg_req.wdata[1]};
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) up_q <= 3'h0;
      else if (!live) up_q <= up_q + 3'h1;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_read_pulse: assert property (live |-> reg_rvalid_q == $past(reg_req.rd_en))
      else $error("read pulse");
   a_idle_zero: assert property (live && !reg_rvalid_q |-> reg_rdata_q == 16'h0000)
      else $error("idle data");
   a_uv_off: assert property (live && supply_fault_det.uv |=> !output_stage_enable_q)
      else $error("uv on");
   a_ov_off: assert property (live && supply_fault_det.ov |=> !output_stage_enable_q)
      else $error("ov on");
   a_on_clean: assert property (live && $rose(output_stage_enable_q) |-> $past(supply_fault_det) == 2'h0)
      else $error("on in fault");
   a_therm_gate: assert property (live |-> thermal_warning_global_q == ($past(thermal_warning_raw) && !$past(therm_mask_q)))
      else $error("thermal gate");
   a_uld_masked: assert property (live && $past(uld_mask_q) |-> !underload_global_q)
      else $error("uld masked");
   a_uld_cause: assert property (live && $rose(underload_global_q) |-> $past(uld_any))
      else $error("uld");
   a_pwm_one: assert property (live |-> half_bridge_one_pwm_q == $past(pwm_input_one))
      else $error("pwm one");
   a_pwm_two: assert property (live && half_bridge_two_pwm_q != $past(pwm_input_two)
      |-> half_bridge_two_pwm_q == $past(pwm_input_one))
      else $error("pwm two");
endmodule
bind sfsc_top sfsc_chk i_chk (.*);

// ===== test/sfsc_host.sv
`timescale 1ns/1ps
module sfsc_host (
   input  wire logic          clk_sys,
   output sfsc_pkg::sfsc_req_t reg_req,
   input  wire logic [15:0]   reg_rdata_q,
   input  wire logic          reg_rvalid_q
);
   initial reg_req = '0;
   // Released fields show inverted values so stale data never looks valid
   task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wr_en: w, rd_en: !w, wdata: d};
      @(posedge clk_sys);
      reg_req <= '{addr: ~a, wr_en: 1'b0, rd_en: 1'b0, wdata: ~d};
      #1 q = reg_rvalid_q ? reg_rdata_q : 16'hdead;
   endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic                   clk_sys = 1'b0;
   logic                   rst_n = 1'b0;
   sfsc_pkg::sfsc_req_t    reg_req;
   sfsc_pkg::sfsc_supply_t supply_fault_det = '0;
   logic [15:0]            reg_rdata_q, q;
   logic                   reg_rvalid_q, output_stage_enable_q, thermal_warning_global_q, underload_global_q;
   logic                   half_bridge_one_pwm_q, half_bridge_two_pwm_q;
   logic                   thermal_warning_raw = 1'b0, pwm_input_one = 1'b0, pwm_input_two = 1'b0;
   logic                   underload_global_clear = 1'b0;
   logic [3:0]             underload_event = 4'h0;
   wire  [3:0]             outs = {thermal_warning_global_q, underload_global_q, half_bridge_one_pwm_q,
                                   half_bridge_two_pwm_q};
   int                     err_total = 0, comparisons = 0;
   always #12.5 clk_sys = ~clk_sys;
   sfsc_top i_dut (.*);
   sfsc_host i_host (.*);
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [5:0] a, input logic [15:0] e);
      i_host.xfer(1'b0, a, 16'h0000, q);
      cmp(q, e);
   endtask
   task automatic close_out;
      $display("errors %0d of %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #20us;
      err_total++;
      close_out;
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rdc(6'h12, 16'h0000);
      rdc(6'h3f, 16'h0000);
      rdc(6'h03, 16'h0000);
      rdc(6'h2a, 16'h0000);
      // Auto recovery first, then latched, each with both fault kinds
      for (int i = 0; i < 4; i++)
      begin
         if (i == 2)
         begin
            i_host.xfer(1'b1, 6'h03, 16'h0010, q);
            rdc(6'h03, 16'h0010);
         end
         @(posedge clk_sys) supply_fault_det <= {!i[0], i[0]};
         rdc(6'h12, i[0] ? 16'h0004 : 16'h0008);
         @(posedge clk_sys) supply_fault_det <= '0;
         repeat (3) @(posedge clk_sys);
         #1 cmp(16'(output_stage_enable_q), 16'(i < 2));
         rdc(6'h12, i[0] ? 16'h0004 : 16'h0008);
         rdc(6'h12, 16'h0000);
         #1 cmp(16'(output_stage_enable_q), 16'h0001);
      end
      @(posedge clk_sys) {thermal_warning_raw, pwm_input_one} <= 2'b11;
      for (int m = 0; m < 2; m++)
      begin
         i_host.xfer(1'b1, 6'h3f, m ? 16'h000b : 16'h0000, q);
         rdc(6'h3f, m ? 16'h000b : 16'h0000);
         @(posedge clk_sys) underload_event <= m ? 4'h8 : 4'h1;
         @(posedge clk_sys) underload_event <= 4'h0;
         #1 cmp(16'(outs), m ? 16'h0003 : 16'h000e);
         // Event and clear together: the event wins unless masked
         @(posedge clk_sys) {underload_event, underload_global_clear} <= 5'h05;
         @(posedge clk_sys) {underload_event, underload_global_clear} <= 5'h01;
         #1 cmp(16'(underload_global_q), 16'(!m));
         @(posedge clk_sys) underload_global_clear <= 1'b0;
         #1 cmp(16'(underload_global_q), 16'h0000);
      end
      close_out;
   end
endmodule
